/* hdl/contact_monitor_spi.sv */
// Digital core of an eight-input contact monitor with serial register port
//
// Function
// - Input pulses shorter than 20 us are discarded before debouncing.
// - One shared debounce interval for all eight inputs, 5 to 100 ms.
// - Normal mode: stable change for full interval updates status, interrupts.
// - Normal mode: reverting before interval expiry changes nothing.
// - Scan mode: detected change enters normal mode and starts debouncing.
// - Scan-started debounce completion updates status, interrupts, back to scan.
// - Scan-started debounce reverting returns to scan with no update.
// - Wetting set by global, pair, continuous/pulse bits; 20 ms; off at reset.
// - Valid change starts one shared wetting pulse on all closed switches.
// - In scan mode wetting current flows only during polling windows and debounce.
// - Direct outputs follow inputs 0 and 1 only if pair off, normal mode.
// - Direct inputs 0 and 1 have no loads, wetting, status or interrupts.
// - Open-drain interrupt asserts low on debounced change of unmasked input.
// - Chip select falling releases interrupt and overheat outputs within four clocks.
// - Changes debounced while chip select is low still assert interrupt.
// - Overheat cuts wetting, asserts overheat pin; inactive if wetting off.
// - Status bit 7 follows the overheat condition, unaffected by pin clear.
// - Status bits 15-8 hold inputs 7-0 closed state; bits 6-0 zero.
// - Both registers are 16 bits, transferred most significant bit first.
// - Status loads on select falling; out on rising, in on falling clock.
// - Master clocks 16 bits; select rising copies shift word to configuration.
// - Select high: serial output released, clock and data ignored.
// - Configuration word layout, all zero after power-up.
// - Scan codes 110/111 select normal mode; others 64 down to 2 ms.
`timescale 1ns/1ps
`default_nettype none
`include "contact_monitor_consts.svh"

module contact_monitor_spi
    import contact_monitor_pkg::*;
#(
    parameter int unsigned DEB_CYC       = `DEB_DEFAULT_MS * 1000 * `CLK_MHZ,
    parameter int unsigned WET_CYC       = `WET_PULSE_MS * 1000 * `CLK_MHZ,
    parameter int unsigned POLL_CYC      = `POLL_US * `CLK_MHZ,
    parameter int unsigned SCAN_BASE_CYC = `SCAN_MIN_MS * 1000 * `CLK_MHZ
) (
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST,
    input  wire logic [7:0] I_SWITCH_INPUTS,
    input  wire logic       I_OVERHEAT,
    input  wire logic       I_SPI_CLK,
    input  wire logic       I_SPI_CS_N,
    input  wire logic       I_SPI_SDI,
    output var  logic       O_SPI_SDO,
    output var  logic       O_SPI_SDO_OE,
    output var  logic       O_INT_N,
    output var  logic       O_INT_N_OE,
    output var  logic       O_OVERHEAT_FLAG_N,
    output var  logic       O_OVERHEAT_FLAG_N_OE,
    output var  logic       O_DIRECT_OUT_ZERO,
    output var  logic       O_DIRECT_OUT_ZERO_OE,
    output var  logic       O_DIRECT_OUT_ONE,
    output var  logic       O_DIRECT_OUT_ONE_OE,
    output var  logic [7:0] O_WET_EN,
    output var  logic [7:0] O_SENSE_EN,
    output var  logic [7:0] O_PULL_DOWN
);

    localparam logic [11:0] GLITCH_LAST = 12'(`GLITCH_CYC - 1);

    // Scan period in cycles for a periodic code: doubles per step below 5
    function automatic logic [31:0] scan_period(input logic [2:0] code);
        logic [2:0] shift;
        shift = `SCAN_CODE_MIN - code;
        scan_period = 32'(SCAN_BASE_CYC) << shift;
    endfunction : scan_period

    // Codes 110 and 111 mean continuous sensing
    function automatic logic is_continuous(input logic [2:0] code);
        is_continuous = (code >= `SCAN_CODE_CONT);
    endfunction : is_continuous

    logic [7:0]  sw_meta;
    logic [7:0]  sw_sync;
    logic [7:0]  sw_filt;
    logic [7:0]  recorded;
    logic [7:0]  cand;
    logic        cs_meta;
    logic        cs_sync;
    logic        cs_prev;
    logic        ot_meta;
    logic        ot_sync;
    logic        ot_prev;
    logic        ot_pin;
    logic        int_pend;
    logic        commit;
    logic        commit_irq;
    logic [15:0] cfg;
    logic [15:0] status_snap;
    logic [15:0] rx_word;
    logic        link_sdo;
    logic [31:0] phase_cnt;
    logic [31:0] wet_cnt;
    mon_state_t  state;

    logic        cs_fall;
    logic        cs_rise;
    logic        cont_mode;
    logic        pair_on;
    logic [7:0]  tracked;
    logic [7:0]  batt;
    logic [7:0]  closed;
    logic [7:0]  diff;
    logic [31:0] idle_len;
    logic        window;
    logic        wet_time;
    logic        ot_cut;
    logic [7:0]  wet_ok;
    logic        direct_en;
    mon_state_t  rest_state;

    // Configuration fields and derived selections
    assign cont_mode = is_continuous(cfg[`CFG_SCAN_HI:`CFG_SCAN_LO]);
    assign pair_on   = cfg[`CFG_PAIR_SENSE];
    // Inputs 0 and 1 drop out of monitoring while they are direct inputs
    assign tracked   = {6'h3F, pair_on, pair_on};
    assign batt      = {cfg[`CFG_UPPER_POL], cfg[`CFG_UPPER_POL],
                        cfg[`CFG_LOWER_POL], cfg[`CFG_LOWER_POL], 4'h0};
    // Ground switches read low when closed, battery switches read high
    assign closed    = ~(sw_filt ^ batt);
    assign diff      = (closed ^ recorded) & tracked;
    assign rest_state = cont_mode ? ST_NORMAL : ST_SCAN_IDLE;
    assign idle_len  = scan_period(cfg[`CFG_SCAN_HI:`CFG_SCAN_LO])
                       - 32'(POLL_CYC);

    // Chip select edges seen after the synchroniser
    assign cs_fall = cs_prev & ~cs_sync;
    assign cs_rise = ~cs_prev & cs_sync;

    // Two-stage synchronisers; switches reset to the open ground level
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sw_meta <= 8'hFF;
            sw_sync <= 8'hFF;
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            ot_meta <= 1'b0;
            ot_sync <= 1'b0;
        end else begin
            sw_meta <= I_SWITCH_INPUTS;
            sw_sync <= sw_meta;
            cs_meta <= I_SPI_CS_N;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            ot_meta <= I_OVERHEAT;
            ot_sync <= ot_meta;
        end
    end

    // Glitch filter per input: a new level must hold for the whole reject
    // time before the debouncer sees it, so short spikes never start it.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_deglitch
            logic [11:0] gl_cnt;
            always_ff @(posedge I_REF_CLK) begin
                if (I_RST) begin
                    gl_cnt      <= 12'h000;
                    sw_filt[gi] <= 1'b1;
                end else if (sw_sync[gi] == sw_filt[gi]) begin
                    gl_cnt      <= 12'h000;
                end else if (gl_cnt == GLITCH_LAST) begin
                    gl_cnt      <= 12'h000;
                    sw_filt[gi] <= sw_sync[gi];
                end else begin
                    gl_cnt      <= gl_cnt + 12'h001;
                end
            end
        end
    endgenerate

    // Monitor sequencer with one shared timer for scan, poll and debounce.
    // The timer restarts whenever the candidate pattern moves, so each
    // input's final level must hold the full interval before it counts.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            state      <= ST_SCAN_IDLE;
            phase_cnt  <= 32'h0000_0000;
            recorded   <= 8'h00;
            cand       <= 8'h00;
            commit     <= 1'b0;
            commit_irq <= 1'b0;
        end else begin
            commit     <= 1'b0;
            commit_irq <= 1'b0;
            phase_cnt  <= phase_cnt + 32'h0000_0001;
            case (state)
                ST_NORMAL: begin
                    phase_cnt <= 32'h0000_0000;
                    if (!cont_mode) begin
                        state <= ST_SCAN_IDLE;
                    end else if (diff != 8'h00) begin
                        state <= ST_DEBOUNCE;
                        cand  <= closed;
                    end
                end
                ST_SCAN_IDLE: begin
                    if (cont_mode) begin
                        state     <= ST_NORMAL;
                        phase_cnt <= 32'h0000_0000;
                    end else if (phase_cnt >= idle_len - 32'h0000_0001) begin
                        state     <= ST_POLL;
                        phase_cnt <= 32'h0000_0000;
                    end
                end
                ST_POLL: begin
                    if (cont_mode) begin
                        state     <= ST_NORMAL;
                        phase_cnt <= 32'h0000_0000;
                    end else if (phase_cnt == 32'(POLL_CYC - 1)) begin
                        phase_cnt <= 32'h0000_0000;
                        cand      <= closed;
                        // A change seen while polling switches to debounce
                        state <= (diff != 8'h00) ? ST_DEBOUNCE
                                                 : ST_SCAN_IDLE;
                    end
                end
                ST_DEBOUNCE: begin
                    if (diff == 8'h00) begin
                        state     <= rest_state;
                        phase_cnt <= 32'h0000_0000;
                    end else if ((closed & tracked) != (cand & tracked)) begin
                        cand      <= closed;
                        phase_cnt <= 32'h0000_0000;
                    end else if (phase_cnt == 32'(DEB_CYC - 1)) begin
                        recorded   <= (recorded & ~tracked)
                                      | (closed & tracked);
                        commit     <= 1'b1;
                        commit_irq <= |(diff & ~cfg[`CFG_MASK_HI:`CFG_MASK_LO]);
                        state      <= rest_state;
                        phase_cnt  <= 32'h0000_0000;
                    end
                end
                default: begin
                    state     <= ST_SCAN_IDLE;
                    phase_cnt <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Interrupt flag: a change committed in the same cycle as the select
    // falling edge keeps the flag set, so no event is lost mid-frame.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            int_pend <= 1'b0;
        end else if (commit_irq) begin
            int_pend <= 1'b1;
        end else if (cs_fall) begin
            int_pend <= 1'b0;
        end
    end

    // Overheat pin latch: asserted on a new overheat event, released on
    // select falling even while the condition lasts.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ot_prev <= 1'b0;
            ot_pin  <= 1'b0;
        end else begin
            ot_prev <= ot_cut;
            if (ot_cut && !ot_prev) begin
                ot_pin <= 1'b1;
            end else if (cs_fall) begin
                ot_pin <= 1'b0;
            end
        end
    end

    // Protection only acts while the global wetting enable is set
    assign ot_cut = ot_sync & cfg[`CFG_WET_EN];

    // Shared wetting pulse timer; a new commit reloads it, so closely
    // spaced closures stretch the pulse rather than giving two.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            wet_cnt <= 32'h0000_0000;
        end else if (commit) begin
            wet_cnt <= 32'(WET_CYC);
        end else if (wet_cnt != 32'h0000_0000) begin
            wet_cnt <= wet_cnt - 32'h0000_0001;
        end
    end

    // Wetting and sense gating: in scan mode only the poll window and debounce open it
    assign window   = (state != ST_SCAN_IDLE);
    assign wet_time = cfg[`CFG_WET_CONT] | (wet_cnt != 32'h0000_0000);
    assign wet_ok   = {6'h3F, pair_on, pair_on}
                      & {8{cfg[`CFG_WET_EN] & ~ot_cut}};
    assign direct_en = ~pair_on & cont_mode;

    // Output drivers, all registered; open-drain data bits are held low
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_WET_EN             <= 8'h00;
            O_SENSE_EN           <= 8'h00;
            O_PULL_DOWN          <= 8'h00;
            O_INT_N              <= 1'b0;
            O_INT_N_OE           <= 1'b0;
            O_OVERHEAT_FLAG_N    <= 1'b0;
            O_OVERHEAT_FLAG_N_OE <= 1'b0;
            O_DIRECT_OUT_ZERO    <= 1'b0;
            O_DIRECT_OUT_ZERO_OE <= 1'b0;
            O_DIRECT_OUT_ONE     <= 1'b0;
            O_DIRECT_OUT_ONE_OE  <= 1'b0;
            O_SPI_SDO_OE         <= 1'b0;
        end else begin
            O_WET_EN    <= wet_ok & recorded & {8{window & wet_time}};
            O_SENSE_EN  <= {6'h3F, pair_on, pair_on} & {8{window}};
            O_PULL_DOWN <= batt;
            O_INT_N              <= 1'b0;
            O_INT_N_OE           <= int_pend;
            O_OVERHEAT_FLAG_N    <= 1'b0;
            O_OVERHEAT_FLAG_N_OE <= ot_pin;
            O_DIRECT_OUT_ZERO    <= sw_sync[0];
            O_DIRECT_OUT_ZERO_OE <= direct_en;
            O_DIRECT_OUT_ONE     <= sw_sync[1];
            O_DIRECT_OUT_ONE_OE  <= direct_en;
            O_SPI_SDO_OE         <= ~cs_sync;
        end
    end

    // Status snapshot tracks live state while idle and freezes once select
    // goes low; the link side reads it only after that, so it is stable.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            status_snap <= 16'h0000;
        end else if (cs_sync) begin
            status_snap <= {recorded, ot_sync, 7'h00};
        end
    end

    // Configuration load on select rising; the link clock is idle by then
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            cfg <= `CFG_RESET;
        end else if (cs_rise) begin
            cfg <= rx_word;
        end
    end

    // Serial shifter on the master's clock
    contact_spi_link u_link (
        .i_sclk        (I_SPI_CLK),
        .i_cs_n        (I_SPI_CS_N),
        .i_sdi         (I_SPI_SDI),
        .i_status_snap (status_snap),
        .o_sdo         (link_sdo),
        .o_rx_word     (rx_word)
    );

    assign O_SPI_SDO = link_sdo;

endmodule : contact_monitor_spi

`default_nettype wire

/* hdl/contact_monitor_consts.svh */
// Constants of the contact monitor: bit positions, reset values, timings
`ifndef CONTACT_MONITOR_CONSTS_SVH
`define CONTACT_MONITOR_CONSTS_SVH

// Reference clock rate in MHz, cycles per microsecond
`define CLK_MHZ          125

// Glitch rejection time in microseconds and its cycle count
`define GLITCH_US        20
`define GLITCH_CYC       (`GLITCH_US * `CLK_MHZ)

// Debounce interval in milliseconds: legal span and default
`define DEB_MIN_MS       5
`define DEB_MAX_MS       100
`define DEB_DEFAULT_MS   20

// Wetting pulse length in milliseconds
`define WET_PULSE_MS     20

// Polling window in microseconds and shortest scan period in milliseconds
`define POLL_US          250
`define SCAN_MIN_MS      2

// Configuration word reset value and field positions
`define CFG_RESET        16'h0000
`define CFG_WET_CONT     15
`define CFG_SCAN_HI      14
`define CFG_SCAN_LO      12
`define CFG_WET_EN       11
`define CFG_PAIR_SENSE   10
`define CFG_UPPER_POL    9
`define CFG_LOWER_POL    8
`define CFG_MASK_HI      7
`define CFG_MASK_LO      0

// Scan period code of the shortest periodic scan, first continuous code
`define SCAN_CODE_MIN    3'h5
`define SCAN_CODE_CONT   3'h6

// Status word field positions
`define STAT_SW_HI       15
`define STAT_SW_LO       8
`define STAT_OVERHEAT    7

`endif

/* hdl/contact_monitor_pkg.sv */
// Types shared by the contact monitor design files
package contact_monitor_pkg;

    // Sequencer states of the switch monitor
    typedef enum logic [1:0] {
        ST_NORMAL    = 2'b00,
        ST_SCAN_IDLE = 2'b01,
        ST_POLL      = 2'b10,
        ST_DEBOUNCE  = 2'b11
    } mon_state_t;

endpackage : contact_monitor_pkg

/* hdl/contact_spi_link.sv */
// Serial link end that runs on the master's serial clock
`timescale 1ns/1ps
`default_nettype none

module contact_spi_link
    import contact_monitor_pkg::*;
(
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_sdi,
    input  wire logic [15:0] i_status_snap,
    output var  logic        o_sdo,
    output var  logic [15:0] o_rx_word
);

    logic [4:0] bit_idx;

    // Send side: chip select high holds the counter cleared without a clock
    // edge, so a frame always starts at the most significant bit. The
    // snapshot is frozen by the core before the first rising edge arrives.
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_idx <= 5'h00;
            o_sdo   <= 1'b0;
        end else if (bit_idx < 5'h10) begin
            o_sdo   <= i_status_snap[~bit_idx[3:0]];
            bit_idx <= bit_idx + 5'h01;
        end
    end

    // Receive side: data taken on falling edges only while selected
    always_ff @(negedge i_sclk) begin
        if (!i_cs_n) begin
            o_rx_word <= {o_rx_word[14:0], i_sdi};
        end
    end

endmodule : contact_spi_link

`default_nettype wire

/* verification/contact_spi_master.sv */
// Serial link master model that reads status and writes configuration
`timescale 1ns/1ps
`default_nettype none

module contact_spi_master (
    output var  logic o_sclk,
    output var  logic o_cs_n,
    output var  logic o_sdi,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe
);
    // Idle: clock stands still low, select high
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
    end

    // One 16-bit frame, 32 ns clock, MSB first both ways
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        o_cs_n = 1'b0;
        #37;
        for (int b = 15; b >= 0; b--) begin
            o_sclk = 1'b1;
            o_sdi  = tx[b]; // Changed at rising, device takes it falling
            #16;
            // A released data line reads as unknown and so never matches
            rx[b]  = i_sdo_oe ? i_sdo : 1'bx;
            o_sclk = 1'b0;
            #16;
        end
        #8;
        o_cs_n = 1'b1;
        o_sdi  = ~o_sdi; // Line no longer holds the last bit
        #80;
    endtask : xfer
endmodule : contact_spi_master
`default_nettype wire

/* verification/contact_monitor_spi_checker.sv */
// Concurrent checks on the contact monitor top-level ports
`timescale 1ns/1ps
`default_nettype none

module contact_monitor_spi_checker (
    input wire logic       I_REF_CLK,
    input wire logic       I_RST,
    input wire logic       I_OVERHEAT,
    input wire logic       I_SPI_CS_N,
    input wire logic       O_SPI_SDO,
    input wire logic       O_SPI_SDO_OE,
    input wire logic       O_INT_N,
    input wire logic       O_INT_N_OE,
    input wire logic       O_OVERHEAT_FLAG_N,
    input wire logic       O_OVERHEAT_FLAG_N_OE,
    input wire logic       O_DIRECT_OUT_ZERO_OE,
    input wire logic       O_DIRECT_OUT_ONE_OE,
    input wire logic [7:0] O_WET_EN,
    input wire logic [7:0] O_SENSE_EN
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    // Select falling, then a flag released within the sync lag
    sequence s_cs_fall;
        $fell(I_SPI_CS_N);
    endsequence
    sequence s_low_soon(sig);
        ##[1:6] !sig;
    endsequence

    property p_int_clear;
        s_cs_fall |-> s_low_soon(O_INT_N_OE);
    endproperty
    a_int_clear: assert property (p_int_clear)
        else $error("interrupt not released after select fall");
    property p_ot_clear;
        s_cs_fall |-> s_low_soon(O_OVERHEAT_FLAG_N_OE);
    endproperty
    a_ot_clear: assert property (p_ot_clear)
        else $error("overheat pin not released after select fall");
    property p_od_data;
        !O_INT_N && !O_OVERHEAT_FLAG_N;
    endproperty
    a_od_data: assert property (p_od_data)
        else $error("open-drain pin data not low");
    property p_sdo_hiz;
        I_SPI_CS_N [*6] |-> !O_SPI_SDO_OE && !O_SPI_SDO;
    endproperty
    a_sdo_hiz: assert property (p_sdo_hiz)
        else $error("serial output driven while deselected");
    property p_sdo_on;
        !I_SPI_CS_N [*6] |-> O_SPI_SDO_OE;
    endproperty
    a_sdo_on: assert property (p_sdo_on)
        else $error("serial output not driven in frame");
    property p_direct_pair;
        O_DIRECT_OUT_ZERO_OE == O_DIRECT_OUT_ONE_OE;
    endproperty
    a_direct_pair: assert property (p_direct_pair)
        else $error("direct outputs enabled differently");
    property p_direct_off;
        O_DIRECT_OUT_ZERO_OE |-> O_WET_EN[1:0] == 2'h0
            && O_SENSE_EN[1:0] == 2'h0;
    endproperty
    a_direct_off: assert property (p_direct_off)
        else $error("direct inputs still loaded or wetted");
    property p_ot_wet;
        I_OVERHEAT [*6] |-> O_WET_EN == 8'h00;
    endproperty
    a_ot_wet: assert property (p_ot_wet)
        else $error("wetting left on while overheated");
    property p_ot_cause;
        $rose(O_OVERHEAT_FLAG_N_OE) |-> $past(I_OVERHEAT, 2)
            || $past(I_OVERHEAT, 3) || $past(I_OVERHEAT, 4);
    endproperty
    a_ot_cause: assert property (p_ot_cause)
        else $error("overheat pin raised without overheat");
endmodule : contact_monitor_spi_checker

bind contact_monitor_spi contact_monitor_spi_checker checker_inst (
    .I_REF_CLK, .I_RST, .I_OVERHEAT, .I_SPI_CS_N, .O_SPI_SDO,
    .O_SPI_SDO_OE, .O_INT_N, .O_INT_N_OE, .O_OVERHEAT_FLAG_N,
    .O_OVERHEAT_FLAG_N_OE, .O_DIRECT_OUT_ZERO_OE, .O_DIRECT_OUT_ONE_OE,
    .O_WET_EN, .O_SENSE_EN
);
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench of the contact monitor with a serial master model
`timescale 1ns/1ps
`default_nettype none

module tb;
    import contact_monitor_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, ot_in = 1'b0, ot_m = 1'b0;
    logic [7:0]  sw = 8'hFF, rec = 8'h00, wet, sense, pd;
    logic        sclk, cs_n, sdi, sdo, sdo_oe, int_n, int_oe, otf, otf_oe;
    logic        d0, d0_oe, d1, d1_oe;
    logic [31:0] seed = 32'h0000_6601;
    int          num_errors = 0, cmp_count = 0, cycles = 0, i;

    always #4 clk = ~clk;

    contact_monitor_spi #(.DEB_CYC(5000), .WET_CYC(300), .POLL_CYC(20),
        .SCAN_BASE_CYC(100)) contact_monitor_spi_inst (
        .I_REF_CLK(clk), .I_RST(rst), .I_SWITCH_INPUTS(sw),
        .I_OVERHEAT(ot_in), .I_SPI_CLK(sclk), .I_SPI_CS_N(cs_n),
        .I_SPI_SDI(sdi), .O_SPI_SDO(sdo), .O_SPI_SDO_OE(sdo_oe),
        .O_INT_N(int_n), .O_INT_N_OE(int_oe), .O_OVERHEAT_FLAG_N(otf),
        .O_OVERHEAT_FLAG_N_OE(otf_oe), .O_DIRECT_OUT_ZERO(d0),
        .O_DIRECT_OUT_ZERO_OE(d0_oe), .O_DIRECT_OUT_ONE(d1),
        .O_DIRECT_OUT_ONE_OE(d1_oe), .O_WET_EN(wet), .O_SENSE_EN(sense),
        .O_PULL_DOWN(pd));

    contact_spi_master contact_spi_master_inst (.o_sclk(sclk),
        .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One frame: the status read back is compared with the model
    task automatic frame(input logic [15:0] v);
        logic [15:0] rx;
        contact_spi_master_inst.xfer(v, rx);
        check("status", {rec, ot_m, 7'h00}, rx);
        repeat (8) @(negedge clk);
    endtask : frame

    // Bounded wait for the interrupt, then its level is compared
    task automatic wait_int(input int n, input logic exp);
        int k;
        for (k = 0; k < n && int_oe !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        check("int", {15'h0000, exp}, {15'h0000, int_oe});
    endtask : wait_int

    // Hang guard: about one and a half times the longest expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        check("wet", 16'h0000, {8'h00, wet});
        check("sense", 16'h0000, {8'h00, sense});
        check("pd", 16'h0000, {8'h00, pd});
        frame(16'h6C00);
        // Normal mode: close then open one random ground-side input
        i = 2 + int'(xs() % 6);
        sw[i] = 1'b0;
        wait_int(9000, 1'b1);
        rec[i] = 1'b1;
        check("wet", 16'h0001, {15'h0000, wet[i]});
        check("sense", 16'h00FF, {8'h00, sense});
        frame(16'h6C00);
        sw[i] = 1'b1;
        wait_int(9000, 1'b1);
        rec[i] = 1'b0;
        frame(16'h6C00);
        // Short glitch, then a change reverting inside the debounce
        for (int j = 0; j < 2; j++) begin
            sw[4] = 1'b0;
            repeat (j ? 4000 : 1000) @(negedge clk);
            sw[4] = 1'b1;
            wait_int(9000, 1'b0);
            frame(16'h6C00);
        end
        // Masked input updates status but raises nothing
        frame(16'h6C40);
        sw[6] = 1'b0;
        wait_int(9000, 1'b0);
        rec[6] = 1'b1;
        frame(16'h6800);
        // Direct inputs in normal mode with pair sensing off
        check("d_oe", 16'h0003, {14'h0000, d1_oe, d0_oe});
        sw[0] = 1'b0;
        repeat (10) @(negedge clk);
        check("d_out", 16'h0002, {14'h0000, d1, d0});
        wait_int(9000, 1'b0);
        frame(16'h0800 | (16'(xs() % 6) << 12));
        sw[0] = 1'b1;
        check("d_oe", 16'h0000, {14'h0000, d1_oe, d0_oe});
        // Scan mode: a change wakes the monitor and commits
        sw[3] = 1'b0;
        wait_int(20000, 1'b1);
        rec[3] = 1'b1;
        frame(16'h6C00);
        // Overheat cuts wetting; status bit outlives the pin clear
        ot_in = 1'b1;
        ot_m  = 1'b1;
        repeat (10) @(negedge clk);
        check("ot_pin", 16'h0001, {15'h0000, otf_oe});
        check("wet", 16'h0000, {8'h00, wet});
        frame(16'h6C00);
        check("ot_pin", 16'h0000, {15'h0000, otf_oe});
        frame(16'h6C00);
        ot_in = 1'b0;
        ot_m  = 1'b0;
        repeat (10) @(negedge clk);
        frame(16'h6C00);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
